/* design/ass_consts.vh */
// Constants for the acquisition scan sequencer
`ifndef ASS_CONSTS_VH
`define ASS_CONSTS_VH
`define ASS_CLK_HZ        40000000
`define ASS_RATE_MIN_MHZ  750
`define ASS_RATE_MAX_HZ   500000
`define ASS_DIV_MIN       (`ASS_CLK_HZ / `ASS_RATE_MAX_HZ)
`define ASS_DIV_MAX       ((`ASS_CLK_HZ / `ASS_RATE_MIN_MHZ) * 1000)
`define ASS_DIV_W         26
`define ASS_LIST_MAX      1024
`define ASS_IDX_W         10
`define ASS_SCAN_MAX      256
`define ASS_SCAN_W        8
`define ASS_ENTRY_W       16
`define ASS_DATA_W        16
`define ASS_WORD_W        26
`define ASS_FIFO_DEPTH    16
`define ASS_FIFO_AW       4
`define ASS_CLK_INT       1'h0
`define ASS_CLK_EXT       1'h1
`define ASS_MODE_CONT     2'h0
`define ASS_MODE_RT_INT   2'h1
`define ASS_MODE_RT_EXT   2'h2
`define ASS_MODE_RT_SPT   2'h3
`define ASS_TRIG_SW       2'h0
`define ASS_TRIG_EXT      2'h1
`define ASS_TRIG_THRESH   2'h2
`define ASS_ST_IDLE       3'h0
`define ASS_ST_ARMED      3'h1
`define ASS_ST_SCAN       3'h2
`define ASS_ST_WAIT_RT    3'h3
`define ASS_ST_DRAIN      3'h4
`define ASS_ST_SINGLE     3'h5
`define ASS_ST_SINGLE_W   3'h6
`endif

/* design/ass_fifo.v */
// Sample FIFO with valid/ready on both sides
`timescale 1ns/100ps
`include "ass_consts.vh"
module ass_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;
  // ==========================================
  // Storage
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always @* begin
    out_data = mem[rd_ptr[AW-1:0]];
  end
  // ==========================================
  // Pointers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* design/ass_sequencer.v */
// Acquisition scan sequencer: pacing, scan modes, stop handling
// Notes on behaviour
// (R1) Internal pacing rate 0.75 S/s to 500 kS/s
// (R2) External pacing on falling clock edge
// (R3) Digital and counter entries share pacing pulses
// (R4) Single value converts at once, unpaced
// (R5) Single value ends itself, no stop
// (R6) Orderly stop finishes, delivers, ignores triggers
// (R7) Abrupt stop halts, discards, ignores triggers
// (R8) Continuous scan wraps list until stopped
// (R9) One list entry per pacing pulse
// (R10) Software, external edge, threshold start triggers
// (R11) List to 1024 entries, 256 scans
// (R12) Internal retrigger: scan count, idle, repeat
// (R13) Retrigger rate sets group start period
// (R14) Host keeps retrigger period long enough
// (R15) External retrigger: scan count, idle, repeat
// (R16) Retrigger edges ignored while scanning
// (R17) Host sets internal retrigger parameters
// (R18) Host sets external retrigger parameters
// (R19) Any start trigger in external retrigger
// (R20) Scan-per-trigger uses external trigger twice
// (R21) External trigger edge polarity selectable
// (R22) Threshold fires on upward crossing
// (R23) Idle pacing pulses start nothing
`timescale 1ns/100ps
`include "ass_consts.vh"
module ass_sequencer (
  input  wire                      CORE_CLK,
  input  wire                      NRST,
  input  wire                      CLK_SRC,
  input  wire [`ASS_DIV_W-1:0]     PACE_DIV,
  input  wire [`ASS_DIV_W-1:0]     RETRIG_DIV,
  input  wire [1:0]                SCAN_MODE,
  input  wire [1:0]                TRIG_SRC,
  input  wire                      TRIG_FALLING,
  input  wire [`ASS_DATA_W-1:0]    THRESHOLD,
  input  wire [`ASS_IDX_W-1:0]     LIST_LAST,
  input  wire [`ASS_SCAN_W-1:0]    SCAN_COUNT_M1,
  input  wire                      START,
  input  wire                      STOP_ORDERLY,
  input  wire                      STOP_ABRUPT,
  input  wire                      SINGLE_REQ,
  input  wire [`ASS_ENTRY_W-1:0]   SINGLE_ENTRY,
  input  wire                      EXT_SAMPLE_CLK,
  input  wire                      EXT_TRIG,
  output reg  [`ASS_IDX_W-1:0]     LIST_ADDR,
  input  wire [`ASS_ENTRY_W-1:0]   LIST_ENTRY,
  output reg                       CONV_START,
  output reg  [`ASS_ENTRY_W-1:0]   CONV_ENTRY,
  input  wire                      CONV_DONE,
  input  wire [`ASS_DATA_W-1:0]    CONV_DATA,
  output wire [`ASS_WORD_W-1:0]    SAMPLE_DATA,
  output wire                      SAMPLE_VALID,
  input  wire                      SAMPLE_READY,
  output reg  [`ASS_DATA_W-1:0]    SINGLE_DATA,
  output reg                       SINGLE_DONE,
  output wire                      BUSY,
  output wire                      OVERFLOW
);
  reg  [2:0]               state;
  reg  [2:0]               next_state;
  reg  [1:0]               clk_sync;
  reg  [1:0]               trig_sync;
  reg                      clk_prev;
  reg                      trig_prev;
  reg  [`ASS_DIV_W-1:0]    pace_cnt;
  reg  [`ASS_DIV_W-1:0]    rt_cnt;
  reg  [`ASS_SCAN_W-1:0]   scan_num;
  reg                      conv_busy;
  reg                      first_slot;
  reg  [`ASS_DATA_W-1:0]   prev_first;
  reg                      prev_ok;
  reg                      overflow;
  wire                     pace_int;
  wire                     pace_ext;
  wire                     pace;
  wire                     trig_edge;
  wire                     thresh_hit;
  wire                     start_trig;
  wire                     rt_tick;
  wire                     list_end;
  wire                     group_end;
  wire                     fifo_in_ready;
  wire                     scanning;
  wire                     take;
  wire                     store;
  wire [`ASS_DIV_W-1:0]    pace_lim;
  wire [`ASS_DIV_W-1:0]    rt_lim;
  wire                     pace_hold;
  localparam [`ASS_DIV_W-1:0] div_lo = `ASS_DIV_MIN;
  localparam [`ASS_DIV_W-1:0] div_hi = `ASS_DIV_MAX;
  assign scanning = (state == `ASS_ST_SCAN);
  // ==========================================
  // Pin synchronisers and edges
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      clk_sync  <= 2'h0;
      trig_sync <= 2'h0;
      clk_prev  <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      clk_sync  <= {clk_sync[0], EXT_SAMPLE_CLK};
      trig_sync <= {trig_sync[0], EXT_TRIG};
      clk_prev  <= clk_sync[1];
      trig_prev <= trig_sync[1];
    end
  end
  // (R2) Falling edge paces
  assign pace_ext  = clk_prev & ~clk_sync[1];
  // (R21) Selected trigger polarity
  assign trig_edge = TRIG_FALLING ? (trig_prev & ~trig_sync[1]) : (~trig_prev & trig_sync[1]);
  // ==========================================
  // Rate generators
  // (R1) Divider clamped to range
  assign pace_lim = (PACE_DIV < div_lo) ? div_lo :
                    (PACE_DIV > div_hi) ? div_hi : PACE_DIV;
  // (R13) Retrigger divider clamped
  assign rt_lim   = (RETRIG_DIV < div_lo) ? div_lo :
                    (RETRIG_DIV > div_hi) ? div_hi : RETRIG_DIV;
  assign pace_int = (pace_cnt == {`ASS_DIV_W{1'b0}});
  assign rt_tick  = (rt_cnt == {`ASS_DIV_W{1'b0}});
  // Threshold monitor keeps pacing while armed
  assign pace_hold = (state == `ASS_ST_IDLE) ||
                     (state == `ASS_ST_ARMED && TRIG_SRC != `ASS_TRIG_THRESH);
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pace_cnt <= {`ASS_DIV_W{1'b0}};
      rt_cnt   <= {`ASS_DIV_W{1'b0}};
    end else begin
      if (pace_hold || pace_int) begin
        pace_cnt <= pace_lim - {{(`ASS_DIV_W-1){1'b0}}, 1'b1};
      end else begin
        pace_cnt <= pace_cnt - {{(`ASS_DIV_W-1){1'b0}}, 1'b1};
      end
      // (R13) Period counts from group start
      if (state == `ASS_ST_IDLE || state == `ASS_ST_ARMED || rt_tick) begin
        rt_cnt <= rt_lim - {{(`ASS_DIV_W-1){1'b0}}, 1'b1};
      end else begin
        rt_cnt <= rt_cnt - {{(`ASS_DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end
  // (R3) One pulse for all entries
  assign pace = (CLK_SRC == `ASS_CLK_EXT) ? pace_ext : pace_int;
  // ==========================================
  // Start triggers
  // (R22) Upward crossing of first entry
  assign thresh_hit = prev_ok && (prev_first <= THRESHOLD) && (CONV_DATA > THRESHOLD);
  // (R10) Three start sources
  // (R19) Any source starts every mode but scan-per-trigger
  // (R20) Scan-per-trigger forces external
  assign start_trig = (SCAN_MODE == `ASS_MODE_RT_SPT) ? trig_edge :
                      (TRIG_SRC == `ASS_TRIG_SW)     ? 1'b1 :
                      (TRIG_SRC == `ASS_TRIG_EXT)    ? trig_edge :
                      (TRIG_SRC == `ASS_TRIG_THRESH) ? (CONV_DONE & first_slot & thresh_hit) :
                      1'b0;
  assign list_end  = (LIST_ADDR == LIST_LAST);
  // (R11) Up to 256 passes
  assign group_end = list_end && (scan_num == SCAN_COUNT_M1) && (SCAN_MODE != `ASS_MODE_CONT);
  // (R9) One entry per pulse
  // (R23) Pulses only count while scanning
  assign take  = scanning && pace && !conv_busy && !STOP_ABRUPT;
  assign store = CONV_DONE && conv_busy && (state != `ASS_ST_SINGLE_W) &&
                 (state != `ASS_ST_ARMED);
  // ==========================================
  // Sequencer state
  always @* begin
    next_state = state;
    case (state)
      `ASS_ST_IDLE: begin
        if (SINGLE_REQ) begin
          next_state = `ASS_ST_SINGLE;
        end else if (START) begin
          next_state = `ASS_ST_ARMED;
        end
      end
      `ASS_ST_ARMED: begin
        if (STOP_ABRUPT || STOP_ORDERLY) begin
          next_state = `ASS_ST_IDLE;
        end else if (start_trig) begin
          next_state = `ASS_ST_SCAN;
        end
      end
      `ASS_ST_SCAN: begin
        // (R7) Abrupt stop halts at once
        if (STOP_ABRUPT) begin
          next_state = `ASS_ST_IDLE;
        // (R6) Orderly stop drains
        end else if (STOP_ORDERLY) begin
          next_state = `ASS_ST_DRAIN;
        end else if (take && group_end) begin
          next_state = `ASS_ST_WAIT_RT;
        end
      end
      `ASS_ST_WAIT_RT: begin
        if (STOP_ABRUPT) begin
          next_state = `ASS_ST_IDLE;
        end else if (STOP_ORDERLY) begin
          next_state = `ASS_ST_DRAIN;
        // (R12) Internal retrigger restarts
        end else if (SCAN_MODE == `ASS_MODE_RT_INT && rt_tick) begin
          next_state = `ASS_ST_SCAN;
        // (R15) External retrigger restarts
        end else if (SCAN_MODE != `ASS_MODE_RT_INT && trig_edge) begin
          next_state = `ASS_ST_SCAN;
        end
      end
      `ASS_ST_DRAIN: begin
        if (STOP_ABRUPT) begin
          next_state = `ASS_ST_IDLE;
        end else if (!conv_busy && !SAMPLE_VALID) begin
          next_state = `ASS_ST_IDLE;
        end
      end
      // (R4) Unpaced single conversion
      `ASS_ST_SINGLE: begin
        next_state = `ASS_ST_SINGLE_W;
      end
      // (R5) Stop inputs not looked at
      `ASS_ST_SINGLE_W: begin
        if (CONV_DONE) begin
          next_state = `ASS_ST_IDLE;
        end
      end
      default: begin
        next_state = `ASS_ST_IDLE;
      end
    endcase
  end
  // (R16) Retrigger edges only in wait state
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state       <= `ASS_ST_IDLE;
      LIST_ADDR   <= {`ASS_IDX_W{1'b0}};
      scan_num    <= {`ASS_SCAN_W{1'b0}};
      CONV_START  <= 1'b0;
      CONV_ENTRY  <= {`ASS_ENTRY_W{1'b0}};
      conv_busy   <= 1'b0;
      first_slot  <= 1'b0;
      prev_first  <= {`ASS_DATA_W{1'b0}};
      prev_ok     <= 1'b0;
      SINGLE_DATA <= {`ASS_DATA_W{1'b0}};
      SINGLE_DONE <= 1'b0;
      overflow    <= 1'b0;
    end else begin
      state       <= next_state;
      CONV_START  <= 1'b0;
      SINGLE_DONE <= 1'b0;
      if (state == `ASS_ST_IDLE) begin
        LIST_ADDR <= {`ASS_IDX_W{1'b0}};
        scan_num  <= {`ASS_SCAN_W{1'b0}};
        prev_ok   <= 1'b0;
        if (START) begin
          overflow <= 1'b0;
        end
      end
      if (state == `ASS_ST_SINGLE) begin
        CONV_START <= 1'b1;
        CONV_ENTRY <= SINGLE_ENTRY;
        conv_busy  <= 1'b1;
      end
      if (state == `ASS_ST_SINGLE_W && CONV_DONE) begin
        SINGLE_DATA <= CONV_DATA;
        SINGLE_DONE <= 1'b1;
        conv_busy   <= 1'b0;
      end
      // Threshold monitor converts first entry while armed
      if (state == `ASS_ST_ARMED && TRIG_SRC == `ASS_TRIG_THRESH && pace && !conv_busy) begin
        CONV_START <= 1'b1;
        CONV_ENTRY <= LIST_ENTRY;
        conv_busy  <= 1'b1;
        first_slot <= 1'b1;
      end
      if (state == `ASS_ST_ARMED && CONV_DONE && conv_busy) begin
        conv_busy  <= 1'b0;
        prev_first <= CONV_DATA;
        prev_ok    <= 1'b1;
      end
      // (R8) Step and wrap the list
      if (take) begin
        CONV_START <= 1'b1;
        CONV_ENTRY <= LIST_ENTRY;
        conv_busy  <= 1'b1;
        first_slot <= 1'b0;
        if (list_end) begin
          LIST_ADDR <= {`ASS_IDX_W{1'b0}};
          if (group_end || SCAN_MODE == `ASS_MODE_CONT) begin
            scan_num <= {`ASS_SCAN_W{1'b0}};
          end else begin
            scan_num <= scan_num + {{(`ASS_SCAN_W-1){1'b0}}, 1'b1};
          end
        end else begin
          LIST_ADDR <= LIST_ADDR + {{(`ASS_IDX_W-1){1'b0}}, 1'b1};
        end
      end else if (store) begin
        conv_busy <= 1'b0;
        if (!fifo_in_ready) begin
          overflow <= 1'b1;
        end
      end
      // (R7) Abrupt stop drops conversion in flight
      if (STOP_ABRUPT && state != `ASS_ST_SINGLE_W && state != `ASS_ST_SINGLE) begin
        conv_busy <= 1'b0;
      end
    end
  end
  // ==========================================
  // Sample buffer
  // (R7) Abrupt stop flushes undelivered data
  ass_fifo #(
    .WIDTH (`ASS_WORD_W),
    .DEPTH (`ASS_FIFO_DEPTH),
    .AW    (`ASS_FIFO_AW)
  ) u_fifo (
    .clk       (CORE_CLK),
    .nrst      (NRST),
    .flush     (STOP_ABRUPT),
    .in_data   ({LIST_ADDR, CONV_DATA}),
    .in_valid  (store && !STOP_ABRUPT),
    .in_ready  (fifo_in_ready),
    .out_data  (SAMPLE_DATA),
    .out_valid (SAMPLE_VALID),
    .out_ready (SAMPLE_READY)
  );
  assign BUSY     = (state != `ASS_ST_IDLE);
  assign OVERFLOW = overflow;
endmodule

/* verif/ass_seq_properties.sv */
// Port checker for the acquisition scan sequencer
`timescale 1ns/100ps
`include "ass_consts.vh"
module ass_seq_properties (
  input wire                   CORE_CLK,
  input wire                   NRST,
  input wire                   START,
  input wire [1:0]             TRIG_SRC,
  input wire                   STOP_ABRUPT,
  input wire                   SINGLE_REQ,
  input wire                   CONV_START,
  input wire                   CONV_DONE,
  input wire [`ASS_WORD_W-1:0] SAMPLE_DATA,
  input wire                   SAMPLE_VALID,
  input wire                   SAMPLE_READY,
  input wire                   SINGLE_DONE,
  input wire                   BUSY,
  input wire                   OVERFLOW
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  conv_pulse_a: assert property (CONV_START |=> !CONV_START [*3])
    else $error("conversion start repeated too soon");
  idle_noconv_a: assert property (!BUSY && !$past(BUSY) |-> !CONV_START)
    else $error("conversion started while idle");
  single_go_a: assert property (SINGLE_REQ && !BUSY |-> ##[1:3] CONV_START)
    else $error("single request not converted");
  single_end_a: assert property (SINGLE_DONE |-> ##[0:2] !BUSY)
    else $error("single conversion did not end");
  start_busy_a: assert property (START && !SINGLE_REQ && !BUSY |=> BUSY)
    else $error("start did not arm");
  sample_hold_a: assert property (SAMPLE_VALID && !SAMPLE_READY && !STOP_ABRUPT
    && !$past(STOP_ABRUPT) |=> SAMPLE_VALID && $stable(SAMPLE_DATA))
    else $error("pending sample changed");
  abrupt_flush_a: assert property (STOP_ABRUPT && BUSY && !SINGLE_DONE
    |-> ##[1:3] (!BUSY && !SAMPLE_VALID))
    else $error("abrupt stop did not flush");
  result_deliver_a: assert property ((CONV_DONE && BUSY && !STOP_ABRUPT
    && TRIG_SRC != `ASS_TRIG_THRESH) ##1
    !STOP_ABRUPT |-> ##[0:1] (SAMPLE_VALID || SINGLE_DONE))
    else $error("result not delivered");
  overflow_keep_a: assert property (OVERFLOW && !START |=> OVERFLOW)
    else $error("overflow flag dropped");
endmodule
bind ass_sequencer ass_seq_properties u_props (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .START(START), .TRIG_SRC(TRIG_SRC), .STOP_ABRUPT(STOP_ABRUPT), .SINGLE_REQ(SINGLE_REQ),
  .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .SAMPLE_DATA(SAMPLE_DATA),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY), .SINGLE_DONE(SINGLE_DONE),
  .BUSY(BUSY), .OVERFLOW(OVERFLOW));

/* verif/ass_conv_model.sv */
// Converter and list table model facing the sequencer
`timescale 1ns/100ps
module ass_conv_model #(
  parameter LAT = 6
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [9:0]  list_addr,
  output wire [15:0] list_entry,
  input  wire        conv_start,
  input  wire [15:0] conv_entry,
  output reg         conv_done,
  output reg  [15:0] conv_data
);
  reg [7:0]  cnt;
  reg [15:0] held;
  // ==========================================================
  // Table entry encodes its own index
  assign list_entry = {6'h28, list_addr};
  // ==========================================================
  // Result only valid with done, scrambled otherwise
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 8'h00;
      held <= 16'h0000;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        held <= conv_entry;
        cnt <= LAT;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      if (cnt == 8'h01 && !conv_start) begin
        conv_done <= 1'b1;
        conv_data <= held ^ 16'h5A5A;
      end
    end
  end
endmodule

/* verif/ass_sequencer_tb.sv */
// Self-checking bench for the acquisition scan sequencer
`timescale 1ns/100ps
`include "ass_consts.vh"
`define CHK(n, e, g) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
  failures = failures + 1; $display("mismatch %s exp %h got %h", n, e, g); end end
`define WAITC(c, n) k = 0; while (!(c) && k < n) begin @(negedge clk); k = k + 1; end
module ass_sequencer_tb;
  reg         clk, nrst, clk_src, trig_fall, start, stop_o, stop_a, sreq, ext_clk, ext_trig;
  reg         rdy, chk_on;
  reg  [25:0] pace, rdiv;
  reg  [1:0]  mode, tsrc;
  reg  [9:0]  last, exp_idx, pop_idx, pop_nxt;
  reg  [7:0]  m1;
  reg  [15:0] sent;
  wire [9:0]  addr;
  wire [15:0] lent, centry, cdata, sdat;
  wire [25:0] sdata;
  wire        cstart, cdone, svalid, sdone, busy, ovf;
  integer     failures, num_checks, nconv, npop, cyc, k, per, lastc;
  ass_sequencer DUT (.CORE_CLK(clk), .NRST(nrst), .CLK_SRC(clk_src), .PACE_DIV(pace),
    .RETRIG_DIV(rdiv), .SCAN_MODE(mode), .TRIG_SRC(tsrc), .TRIG_FALLING(trig_fall),
    .THRESHOLD(16'h8000), .LIST_LAST(last), .SCAN_COUNT_M1(m1), .START(start),
    .STOP_ORDERLY(stop_o), .STOP_ABRUPT(stop_a), .SINGLE_REQ(sreq), .SINGLE_ENTRY(sent),
    .EXT_SAMPLE_CLK(ext_clk), .EXT_TRIG(ext_trig), .LIST_ADDR(addr), .LIST_ENTRY(lent),
    .CONV_START(cstart), .CONV_ENTRY(centry), .CONV_DONE(cdone), .CONV_DATA(cdata),
    .SAMPLE_DATA(sdata), .SAMPLE_VALID(svalid), .SAMPLE_READY(rdy), .SINGLE_DATA(sdat),
    .SINGLE_DONE(sdone), .BUSY(busy), .OVERFLOW(ovf));
  ass_conv_model CONV (.clk(clk), .nrst(nrst), .list_addr(addr), .list_entry(lent),
    .conv_start(cstart), .conv_entry(centry), .conv_done(cdone), .conv_data(cdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Monitor: list order, pacing period, pops, timeout
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cstart) begin
      per = cyc - lastc;
      lastc = cyc;
    end
    if (cstart && chk_on) begin
      `CHK("entry", {6'h28, exp_idx}, centry)
      exp_idx = (exp_idx == last) ? 10'h000 : exp_idx + 10'h001;
      nconv = nconv + 1;
    end
    if (svalid && rdy) npop = npop + 1;
    if (svalid && rdy && chk_on) begin
      pop_nxt = (pop_idx == last) ? 10'h000 : pop_idx + 10'h001;
      `CHK("sample", {pop_nxt, {6'h28, pop_idx} ^ 16'h5A5A}, sdata)
      pop_idx = pop_nxt;
    end
    if (cyc == 40000) begin
      failures = failures + 1;
      final_report;
    end
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task cfg(input s, input [1:0] md, input [1:0] ts, input [9:0] l, input [7:0] sc, input r);
    begin
      @(posedge clk);
      clk_src <= s; mode <= md; tsrc <= ts; last <= l; m1 <= sc; rdy <= r;
    end
  endtask
  task go;
    begin
      @(posedge clk) start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      exp_idx = 10'h000; pop_idx = 10'h000; nconv = 0; npop = 0; chk_on = 1'b1;
    end
  endtask
  task halt(input ab);
    begin
      @(posedge clk) begin if (ab) stop_a <= 1'b1; else stop_o <= 1'b1; end
      @(posedge clk) begin stop_a <= 1'b0; stop_o <= 1'b0; end
    end
  endtask
  task extp(input integer n);
    repeat (n) begin tick(50); ext_clk <= 1'b1; tick(50); ext_clk <= 1'b0; end
  endtask
  // ==========================================================
  // Scenarios
  task t_single;
    begin
      chk_on = 1'b0;
      @(posedge clk) begin sent <= 16'h0123; sreq <= 1'b1; end
      @(posedge clk) sreq <= 1'b0;
      `WAITC(sdone === 1'b1, 60)
      `CHK("single_done", 1'b1, sdone)
      `CHK("single_data", 16'h0123 ^ 16'h5A5A, sdat)
      `CHK("single_entry", 16'h0123, centry)
      `WAITC(busy === 1'b0, 5)
      `CHK("single_end", 1'b0, busy)
      $display("test single done");
    end
  endtask
  task t_cont;
    begin
      @(posedge clk) pace <= 26'd10;
      cfg(`ASS_CLK_INT, `ASS_MODE_CONT, `ASS_TRIG_SW, 10'd2, 8'd0, 1'b1);
      go;
      @(negedge clk);
      `CHK("armed", 1'b1, busy)
      `WAITC(nconv >= 7, 1000)
      `CHK("pace_period", 80, per)
      halt(0);
      `WAITC(busy === 1'b0, 400)
      tick(20);
      `CHK("delivered", nconv, npop)
      k = nconv;
      tick(300);
      `CHK("no_more", k, nconv)
      @(posedge clk) pace <= 26'd80;
      $display("test continuous done");
    end
  endtask
  task t_fill;
    begin
      cfg(`ASS_CLK_INT, `ASS_MODE_CONT, `ASS_TRIG_SW, 10'd0, 8'd0, 1'b0);
      go;
      `WAITC(nconv >= 18, 2500)
      tick(10);
      @(negedge clk);
      `CHK("overflow", 1'b1, ovf)
      `CHK("full_valid", 1'b1, svalid)
      halt(0);
      tick(20);
      @(posedge clk) rdy <= 1'b1;
      `WAITC(busy === 1'b0 && svalid === 1'b0, 300)
      `CHK("drained", 16, npop)
      $display("test fill done");
    end
  endtask
  task t_abrupt;
    begin
      cfg(`ASS_CLK_INT, `ASS_MODE_CONT, `ASS_TRIG_SW, 10'd2, 8'd0, 1'b0);
      go;
      `WAITC(nconv >= 3, 400)
      `CHK("ovf_clear", 1'b0, ovf)
      halt(1);
      `WAITC(busy === 1'b0, 5)
      `CHK("abrupt_busy", 1'b0, busy)
      `CHK("abrupt_flush", 1'b0, svalid)
      k = nconv;
      @(posedge clk) rdy <= 1'b1;
      tick(300);
      `CHK("abrupt_quiet", k, nconv)
      `CHK("abrupt_pops", 0, npop)
      $display("test abrupt done");
    end
  endtask
  task t_ext;
    begin
      cfg(`ASS_CLK_EXT, `ASS_MODE_CONT, `ASS_TRIG_EXT, 10'd1, 8'd0, 1'b1);
      go;
      extp(3);
      `CHK("armed_idle", 0, nconv)
      @(posedge clk) ext_trig <= 1'b1;
      tick(20);
      extp(5);
      tick(20);
      `CHK("ext_paced", 5, nconv)
      halt(1);
      `WAITC(busy === 1'b0, 10)
      $display("test external clock done");
    end
  endtask
  task t_rtx(input [1:0] md, input [1:0] ts);
    begin
      // host sets triggered scan, external retrigger, count
      // start source setting unused in scan-per-trigger
      cfg(`ASS_CLK_INT, md, ts, 10'd1, 8'd1, 1'b1);
      // falling edge selected, pin idles high
      @(posedge clk) begin trig_fall <= 1'b1; ext_trig <= 1'b1; end
      tick(10);
      go;
      @(posedge clk) ext_trig <= 1'b0;
      tick(200);
      ext_trig <= 1'b1;
      tick(5);
      ext_trig <= 1'b0;
      tick(400);
      `CHK("group_one", 4, nconv)
      ext_trig <= 1'b1;
      tick(300);
      `CHK("group_idle", 4, nconv)
      ext_trig <= 1'b0;
      tick(500);
      `CHK("group_two", 8, nconv)
      halt(1);
      `WAITC(busy === 1'b0, 10)
      $display("test external retrigger done");
    end
  endtask
  task t_rti;
    begin
      cfg(`ASS_CLK_INT, `ASS_MODE_RT_INT, `ASS_TRIG_SW, 10'd1, 8'd0, 1'b1);
      // period well above two pacing periods plus 2 us
      @(posedge clk) rdiv <= 26'd1000;
      go;
      tick(3500);
      `CHK("int_groups", 8, nconv)
      halt(1);
      `WAITC(busy === 1'b0, 10)
      $display("test internal retrigger done");
    end
  endtask
  initial begin
    {nrst, clk_src, trig_fall, start, stop_o, stop_a, sreq, ext_clk, ext_trig, rdy} = 10'h000;
    chk_on = 1'b0; pace = 26'd80; rdiv = 26'd1000; mode = 2'h0; tsrc = 2'h0;
    last = 10'h000; m1 = 8'h00; sent = 16'h0000; exp_idx = 10'h000;
    pop_idx = 10'h000; pop_nxt = 10'h000;
    failures = 0; num_checks = 0; nconv = 0; npop = 0; cyc = 0; per = 0; lastc = 0;
    tick(10);
    @(posedge clk) nrst <= 1'b1;
    t_single;
    t_cont;
    t_fill;
    t_abrupt;
    t_ext;
    t_rtx(`ASS_MODE_RT_EXT, `ASS_TRIG_EXT);
    t_rtx(`ASS_MODE_RT_SPT, 2'h3);
    t_rti;
    final_report;
  end
endmodule
